// >>> logic/iplb_bank.sv
/*
  Interrupt priority level bank: four priority registers, per-source level
  decode, request forwarding to the core, event status, mask and interrupt.
  Assumes peripheral requests and the register port run on clk.
*/
// Behaviour
// - A field of 00 disables its source and 01, 10, 11 give levels 0, 1, 2.
// - Every priority field is 00 after reset so all sources start disabled.
// - Reserved bits read as zero and ignore writes.
// - The CAN register holds wakeup in 7-6, error in 5-4, bus-off in 3-2, 1-0 reserved.
// - Offset 4 holds SPI0 rx full 15-14, SPI1 tx empty 13-12, SPI1 rx full 11-10.
// - Offset 4 holds ports A, B and C in bits 5-4, 3-2 and 1-0.
// - Offset 5 holds decoder1 index, decoder1 home, async1 rx full and rx error in 15-8.
// - Offset 5 holds async1 tx idle 5-4, async1 tx empty 3-2, SPI0 tx empty 1-0.
// - Offset 6 holds timer C ch0 in 15-14 and timer D ch3 to ch0 down to 7-6.
// - Offset 6 holds decoder0 index in 3-2 and decoder0 home in 1-0.
`timescale 1ns/1ps
`default_nettype none
module iplb_bank
  import iplb_pkg::*;
#(
  parameter int unsigned NSRC = IPLB_NSRC
)(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [IPLB_AW-1:0]   addr,
  input  wire logic [IPLB_DW-1:0]   wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [IPLB_DW-1:0]   rdata,
  input  wire logic [NSRC-1:0]      src_req,
  output logic      [NSRC-1:0]      src_pend,
  output iplb_core_req_t            core_req,
  output logic                      irq
);

  logic [IPLB_DW-1:0]   levels [IPLB_NREG];
  logic [IPLB_NEVT-1:0] evt_status;
  logic [IPLB_NEVT-1:0] evt_mask;
  logic                 sup_q;
  logic [63:0]          level_vec;
  logic [NSRC-1:0]      next_pend;
  logic [NSRC-1:0]      src_sup;
  iplb_core_req_t       src_lvl [NSRC];
  iplb_core_req_t       next_core;
  logic                 next_sup;
  logic [IPLB_NEVT-1:0] evt_set;
  logic [IPLB_NEVT-1:0] next_status;

  // Register index and mask lookup, shared by write, read and checks
  function automatic int reg_slot(input logic [IPLB_AW-1:0] a);
    if (a == IPLB_IDX_CAN_GPIO) begin
      return 0;
    end else if (a == IPLB_IDX_SERIAL_GPIO) begin
      return 1;
    end else if (a == IPLB_IDX_DECODER_SCI) begin
      return 2;
    end else if (a == IPLB_IDX_TIMERS_DEC) begin
      return 3;
    end else begin
      return -1;
    end
  endfunction

  function automatic logic [IPLB_DW-1:0] reg_mask(input int slot);
    if (slot == 0) begin
      return IPLB_MASK_CAN_GPIO;
    end else if (slot == 1) begin
      return IPLB_MASK_SERIAL_GPIO;
    end else if (slot == 2) begin
      return IPLB_MASK_DECODER_SCI;
    end else if (slot == 3) begin
      return IPLB_MASK_TIMERS_DEC;
    end else begin
      return '0;
    end
  endfunction

  function automatic logic [1:0] field_of(input logic [63:0] v, input int k);
    return v[IPLB_SRC_POS[k] +: 2];
  endfunction

  assign level_vec = {levels[3], levels[2], levels[1], levels[0]};

  // Priority registers
  genvar r;
  generate
    for (r = 0; r < IPLB_NREG; r++) begin : g_reg
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          levels[r] <= IPLB_RESET_LEVELS;
        end else if (wr && reg_slot(addr) == r) begin
          // Reserved bits are dropped by the per-register masks
          levels[r] <= wdata & reg_mask(r);
        end
      end
    end
  endgenerate

  // Per-source decode
  genvar s;
  generate
    for (s = 0; s < NSRC; s++) begin : g_src
      iplb_level_decode u_dec (
        .req        (src_req[s]),
        .field      (field_of(level_vec, s)),
        .pend       (next_pend[s]),
        .suppressed (src_sup[s]),
        .level      (src_lvl[s])
      );
    end
  endgenerate

  always_comb begin
    next_core = '0;
    for (int k = 0; k < NSRC; k++) begin
      next_core = next_core | src_lvl[k];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_pend <= '0;
      core_req <= '0;
    end else begin
      src_pend <= next_pend;
      core_req <= next_core;
    end
  end

  // Events: a new request at each level, and a request arriving while disabled
  assign next_sup = |src_sup;
  assign evt_set  = {next_sup & ~sup_q,
                     next_core.level2 & ~core_req.level2,
                     next_core.level1 & ~core_req.level1,
                     next_core.level0 & ~core_req.level0};

  // Mask as it will stand after this edge, so irq never lags a mask write
  logic [IPLB_NEVT-1:0] next_mask;

  always_comb begin
    next_mask = evt_mask;
    if (wr && addr == IPLB_IDX_EVT_MASK) begin
      next_mask = wdata[IPLB_NEVT-1:0];
    end
  end

  // Set beats the clear of a status read so a same-cycle event is kept
  always_comb begin
    next_status = evt_status;
    if (rd && addr == IPLB_IDX_EVT_STATUS) begin
      next_status = '0;
    end
    next_status = next_status | evt_set;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sup_q      <= 1'b0;
      evt_status <= IPLB_RESET_EVT;
      irq        <= 1'b0;
    end else begin
      sup_q      <= next_sup;
      evt_status <= next_status;
      irq        <= |(next_status & next_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_mask <= IPLB_RESET_EVT;
    end else if (wr && addr == IPLB_IDX_EVT_MASK) begin
      evt_mask <= wdata[IPLB_NEVT-1:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (!rd) begin
      rdata <= '0;
    end else if (reg_slot(addr) >= 0) begin
      rdata <= levels[reg_slot(addr)] & reg_mask(reg_slot(addr));
    end else if (addr == IPLB_IDX_EVT_STATUS) begin
      rdata <= {{(IPLB_DW-IPLB_NEVT){1'b0}}, evt_status};
    end else if (addr == IPLB_IDX_EVT_MASK) begin
      rdata <= {{(IPLB_DW-IPLB_NEVT){1'b0}}, evt_mask};
    end else begin
      rdata <= '0;
    end
  end

  // Checks
  logic                 rd_q;
  logic [IPLB_AW-1:0]   raddr_q;
  logic                 any_wr;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q    <= 1'b0;
      raddr_q <= '0;
      any_wr  <= 1'b0;
    end else begin
      rd_q    <= rd;
      raddr_q <= addr;
      any_wr  <= any_wr | (wr && reg_slot(addr) >= 0);
    end
  end

  property p_reset_disabled;
    @(posedge clk) disable iff (!rst_b)
      !any_wr |-> (level_vec == '0 && src_pend == '0 && core_req == '0);
  endproperty
  a_reset_disabled: assert property (p_reset_disabled)
    else $error("priority field nonzero before any write");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_b)
      (rd_q && reg_slot(raddr_q) >= 0) |-> ((rdata & ~reg_mask(reg_slot(raddr_q))) == '0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit read as one");

  property p_readback(logic [IPLB_AW-1:0] idx, logic [IPLB_DW-1:0] m);
    @(posedge clk) disable iff (!rst_b)
      (wr && addr == idx) ##1 (rd && addr == idx && !wr) |=> (rdata == ($past(wdata, 2) & m));
  endproperty
  a_readback_can: assert property (p_readback(IPLB_IDX_CAN_GPIO, IPLB_MASK_CAN_GPIO))
    else $error("can register readback wrong");
  a_readback_serial: assert property (p_readback(IPLB_IDX_SERIAL_GPIO, IPLB_MASK_SERIAL_GPIO))
    else $error("serial register readback wrong");
  a_readback_dec: assert property (p_readback(IPLB_IDX_DECODER_SCI, IPLB_MASK_DECODER_SCI))
    else $error("decoder register readback wrong");
  a_readback_tmr: assert property (p_readback(IPLB_IDX_TIMERS_DEC, IPLB_MASK_TIMERS_DEC))
    else $error("timer register readback wrong");

  property p_disabled_suppressed;
    @(posedge clk) disable iff (!rst_b)
      (field_of(level_vec, 0) == IPLB_FIELD_OFF) |=> !src_pend[0];
  endproperty
  a_disabled_suppressed: assert property (p_disabled_suppressed)
    else $error("disabled source forwarded");

  property p_level2_map;
    @(posedge clk) disable iff (!rst_b)
      (src_req[3] && field_of(level_vec, 3) == IPLB_FIELD_L2) |=> (core_req.level2 && src_pend[3]);
  endproperty
  a_level2_map: assert property (p_level2_map)
    else $error("level 2 request not forwarded");

  property p_level0_only;
    @(posedge clk) disable iff (!rst_b)
      (src_req == (1 << 16) && field_of(level_vec, 16) == IPLB_FIELD_L0)
        |=> (core_req == 3'b001);
  endproperty
  a_level0_only: assert property (p_level0_only)
    else $error("level 0 request at wrong level");

  property p_irq_tracks;
    @(posedge clk) disable iff (!rst_b)
      ((evt_status & evt_mask) != '0) |-> irq;
  endproperty
  a_irq_tracks: assert property (p_irq_tracks)
    else $error("interrupt low with unmasked event");

  property p_irq_low;
    @(posedge clk) disable iff (!rst_b)
      ((evt_status & evt_mask) == '0) |-> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt high with no unmasked event");

  // Bits only leave the status register through a status read
  property p_status_sticky;
    @(posedge clk) disable iff (!rst_b)
      !(rd && addr == IPLB_IDX_EVT_STATUS)
        |=> ((evt_status & $past(evt_status)) == $past(evt_status));
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status bit lost without a read");

  property p_status_clear;
    @(posedge clk) disable iff (!rst_b)
      (rd && addr == IPLB_IDX_EVT_STATUS && evt_set == '0) |=> (evt_status == '0);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status read did not clear");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_b)
      !rd |=> (rdata == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data nonzero without a read");

  property p_mask_readback;
    @(posedge clk) disable iff (!rst_b)
      (wr && addr == IPLB_IDX_EVT_MASK) ##1 (rd && addr == IPLB_IDX_EVT_MASK)
        |=> (rdata == IPLB_DW'($past(wdata[IPLB_NEVT-1:0], 2)));
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("mask readback wrong");

  property p_unmapped_zero;
    @(posedge clk) disable iff (!rst_b)
      (rd && reg_slot(addr) < 0 && addr != IPLB_IDX_EVT_STATUS && addr != IPLB_IDX_EVT_MASK)
        |=> (rdata == '0);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read nonzero");

  // A write elsewhere must not disturb the CAN register
  property p_other_write_kept;
    @(posedge clk) disable iff (!rst_b)
      !(wr && reg_slot(addr) == 0) |=> (levels[0] == $past(levels[0]));
  endproperty
  a_other_write_kept: assert property (p_other_write_kept)
    else $error("can register changed without its write");

  property p_core_from_pend;
    @(posedge clk) disable iff (!rst_b)
      (src_pend == '0) |-> (core_req == '0);
  endproperty
  a_core_from_pend: assert property (p_core_from_pend)
    else $error("core request with nothing pending");

  property p_level1_map;
    @(posedge clk) disable iff (!rst_b)
      (src_req[16] && field_of(level_vec, 16) == IPLB_FIELD_L1) |=> core_req.level1;
  endproperty
  a_level1_map: assert property (p_level1_map)
    else $error("level 1 request not forwarded");

  property p_src_forward(int k);
    @(posedge clk) disable iff (!rst_b)
      (src_req[k] && field_of(level_vec, k) != IPLB_FIELD_OFF) |=> src_pend[k];
  endproperty

  property p_pend_cause(int k);
    @(posedge clk) disable iff (!rst_b)
      src_pend[k] |-> $past(src_req[k]);
  endproperty

  genvar q;
  generate
    for (q = 0; q < NSRC; q++) begin : g_chk
      a_src_forward: assert property (p_src_forward(q))
        else $error("enabled request not forwarded");
      a_pend_cause: assert property (p_pend_cause(q))
        else $error("pending without a request");
    end
  endgenerate

  c_status_clear: cover property (@(posedge clk) disable iff (!rst_b)
    rd && addr == IPLB_IDX_EVT_STATUS && evt_status != '0);
  c_level1: cover property (@(posedge clk) disable iff (!rst_b) core_req.level1);
  c_suppressed: cover property (@(posedge clk) disable iff (!rst_b) evt_status[IPLB_EVT_SUP]);
  c_irq: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq));
endmodule
`default_nettype wire

// >>> logic/iplb_level_decode.sv
/*
  Decoder for one 2-bit priority field and its source request.
  Assumes the request comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module iplb_level_decode
  import iplb_pkg::*;
(
  input  wire logic       req,
  input  wire logic [1:0] field,
  output logic            pend,
  output logic            suppressed,
  output iplb_core_req_t  level
);
  always_comb begin
    level = '0;
    case (field)
      IPLB_FIELD_L0: level.level0 = req;
      IPLB_FIELD_L1: level.level1 = req;
      IPLB_FIELD_L2: level.level2 = req;
      default:       level = '0;
    endcase
  end

  assign pend       = req && (field != IPLB_FIELD_OFF);
  assign suppressed = req && (field == IPLB_FIELD_OFF);
endmodule
`default_nettype wire

// >>> logic/iplb_pkg.sv
/*
  Constants, field layout and carrier types of the interrupt priority level bank.
  Assumes a 16-bit word-indexed register port and one system clock.
*/
package iplb_pkg;
  localparam int unsigned IPLB_DW   = 16;
  localparam int unsigned IPLB_AW   = 8;
  localparam int unsigned IPLB_NSRC = 23;
  localparam int unsigned IPLB_NREG = 4;
  localparam int unsigned IPLB_NEVT = 4;

  // Word indices on the register port
  localparam logic [IPLB_AW-1:0] IPLB_IDX_CAN_GPIO     = 8'h03;
  localparam logic [IPLB_AW-1:0] IPLB_IDX_SERIAL_GPIO  = 8'h04;
  localparam logic [IPLB_AW-1:0] IPLB_IDX_DECODER_SCI  = 8'h05;
  localparam logic [IPLB_AW-1:0] IPLB_IDX_TIMERS_DEC   = 8'h06;
  localparam logic [IPLB_AW-1:0] IPLB_IDX_EVT_STATUS   = 8'h10;
  localparam logic [IPLB_AW-1:0] IPLB_IDX_EVT_MASK     = 8'h11;

  // Implemented field bits; everything else is reserved
  localparam logic [IPLB_DW-1:0] IPLB_MASK_CAN_GPIO    = 16'h00fc;
  localparam logic [IPLB_DW-1:0] IPLB_MASK_SERIAL_GPIO = 16'hfc3f;
  localparam logic [IPLB_DW-1:0] IPLB_MASK_DECODER_SCI = 16'hff3f;
  localparam logic [IPLB_DW-1:0] IPLB_MASK_TIMERS_DEC  = 16'hffcf;
  localparam logic [IPLB_DW-1:0] IPLB_RESET_LEVELS     = 16'h0000;
  localparam logic [IPLB_NEVT-1:0] IPLB_RESET_EVT      = 4'h0;

  localparam logic [1:0] IPLB_FIELD_OFF = 2'b00;
  localparam logic [1:0] IPLB_FIELD_L0  = 2'b01;
  localparam logic [1:0] IPLB_FIELD_L1  = 2'b10;
  localparam logic [1:0] IPLB_FIELD_L2  = 2'b11;

  // Low bit of each source field in {timers_dec, decoder_sci, serial_gpio, can_gpio}
  // 0..2 can wakeup/error/busoff, 3..8 spi0 rx, spi1 tx, spi1 rx, ports a/b/c,
  // 9..15 decoder1 index/home, async1 rx full/rx err/tx idle/tx empty, spi0 tx,
  // 16..22 timer c ch0, timer d ch3..ch0, decoder0 index/home
  localparam logic [5:0] IPLB_SRC_POS [IPLB_NSRC] = '{
    6'd6,  6'd4,  6'd2,
    6'd30, 6'd28, 6'd26, 6'd20, 6'd18, 6'd16,
    6'd46, 6'd44, 6'd42, 6'd40, 6'd36, 6'd34, 6'd32,
    6'd62, 6'd60, 6'd58, 6'd56, 6'd54, 6'd50, 6'd48
  };

  // Event bits of the status register
  localparam int unsigned IPLB_EVT_L0  = 0;
  localparam int unsigned IPLB_EVT_L1  = 1;
  localparam int unsigned IPLB_EVT_L2  = 2;
  localparam int unsigned IPLB_EVT_SUP = 3;

  typedef struct packed {
    logic level2;
    logic level1;
    logic level0;
  } iplb_core_req_t;
endpackage

// >>> tb/interrupt_priority_level_bank_tb.sv
/*
  Self-checking bench of the interrupt priority level bank.
  Assumes the bank's register port and request sources share clk.
*/
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_level_bank_tb
  import iplb_pkg::*;
;
  logic                 clk   = 1'b0;
  logic                 rst_b = 1'b0;
  logic [IPLB_AW-1:0]   addr  = '0;
  logic [IPLB_DW-1:0]   wdata = '0;
  logic                 wr    = 1'b0;
  logic                 rd    = 1'b0;
  logic [IPLB_NSRC-1:0] want  = '0;
  logic                 slow  = 1'b0;
  logic                 rd_q  = 1'b0;
  logic [IPLB_DW-1:0]   rdata;
  logic [IPLB_NSRC-1:0] src_req;
  logic [IPLB_NSRC-1:0] src_pend;
  iplb_core_req_t       core_req;
  logic                 irq;
  logic [IPLB_DW-1:0]   notes[$];
  logic [IPLB_DW-1:0]   masks[4];
  logic [IPLB_DW-1:0]   r;
  logic [IPLB_AW-1:0]   idx;
  int                   fail_count = 0;
  int                   checks     = 0;
  int                   seed       = 46;
  int                   pos;

  iplb_bank u_iplb_bank (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .src_req(src_req), .src_pend(src_pend), .core_req(core_req),
    .irq(irq));
  iplb_src_model u_iplb_src_model (.clk(clk), .rst_b(rst_b), .want(want), .slow(slow),
    .src_req(src_req));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [IPLB_NSRC-1:0] got, input logic [IPLB_NSRC-1:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [IPLB_AW-1:0] a, input logic [IPLB_DW-1:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [IPLB_AW-1:0] a, input logic [IPLB_DW-1:0] exp);
    notes.push_back(exp);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) begin
      chk(IPLB_NSRC'(rdata), IPLB_NSRC'(notes.pop_front()));
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    masks = '{IPLB_MASK_CAN_GPIO, IPLB_MASK_SERIAL_GPIO, IPLB_MASK_DECODER_SCI,
              IPLB_MASK_TIMERS_DEC};
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_reg(IPLB_IDX_CAN_GPIO + 8'(i), IPLB_RESET_LEVELS);
    end
    rd_reg(8'h20, 16'h0000);
    // Unmasked level 2 event raises irq, a status read clears it
    wr_reg(IPLB_IDX_EVT_MASK, 16'h0004);
    rd_reg(IPLB_IDX_EVT_MASK, 16'h0004);
    wr_reg(IPLB_IDX_SERIAL_GPIO, 16'hc000);
    want[3] <= 1'b1;
    repeat (4) @(posedge clk);
    chk(irq, 1'b1);
    rd_reg(IPLB_IDX_EVT_STATUS, 16'h0004);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    // A request on a disabled source is only recorded as suppressed
    want[3] <= 1'b0;
    wr_reg(IPLB_IDX_SERIAL_GPIO, 16'h0000);
    wr_reg(IPLB_IDX_EVT_MASK, 16'h0008);
    want[3] <= 1'b1;
    repeat (4) @(posedge clk);
    chk(src_pend, '0);
    chk(irq, 1'b1);
    rd_reg(IPLB_IDX_EVT_STATUS, 16'h0008);
    want <= '0;
    // All-ones first so every reserved bit is tried, then random words
    for (int i = 0; i < 12; i++) begin
      r   = (i < 4) ? 16'hffff : 16'($random(seed));
      idx = IPLB_IDX_CAN_GPIO + 8'(i % 4);
      wr_reg(idx, r);
      rd_reg(idx, r & masks[i % 4]);
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(IPLB_IDX_CAN_GPIO + 8'(i), 16'h0000);
    end
    // Every source at every code, with prompt and slow peripherals
    for (int s = 0; s < IPLB_NSRC; s++) begin
      pos = int'(IPLB_SRC_POS[s]);
      idx = IPLB_IDX_CAN_GPIO + 8'(pos / 16);
      for (int c = 0; c < 4; c++) begin
        slow <= 1'($random(seed));
        want <= IPLB_NSRC'(1) << s;
        wr_reg(idx, 16'(c) << (pos % 16));
        repeat (4) @(posedge clk);
        chk(src_pend, (c != 0) ? (IPLB_NSRC'(1) << s) : '0);
        chk(core_req, (c != 0) ? (IPLB_NSRC'(1) << (c - 1)) : '0);
        // Field placement
        rd_reg(idx, 16'(c) << (pos % 16));
      end
      wr_reg(idx, 16'h0000);
    end
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire

// >>> tb/iplb_src_model.sv
/*
  Peripheral request sources that feed the priority bank.
  Assumes one clock shared with the bank; requests are plain levels.
*/
`timescale 1ns/1ps
`default_nettype none
module iplb_src_model
  import iplb_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [IPLB_NSRC-1:0] want,
  input  wire logic                 slow,
  output logic      [IPLB_NSRC-1:0] src_req
);
  logic [IPLB_NSRC-1:0] stage;

  // A slow peripheral raises its flag one cycle late
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage   <= '0;
      src_req <= '0;
    end else begin
      stage   <= want;
      src_req <= slow ? stage : want;
    end
  end
endmodule
`default_nettype wire
